/* File: src/pcactl_defs.svh */
// register offsets, field positions, reset values and timing of the counter array control block
`ifndef PCACTL_DEFS_SVH
`define PCACTL_DEFS_SVH
`define CA_CTRL 8'hd8
`define CA_RLD_LO 8'hce
`define CA_RLD_HI 8'hcf
`define CA_MODE_BASE 8'hda
`define CA_CMPL_BASE 8'hea
`define CA_CNT_LO 8'he9
`define CA_AUX_BASE 8'hf2
`define CA_CNT_HI 8'hf9
`define CA_CMPH_BASE 8'hfa
`define CA_PAGE_LO 4'h0
`define CA_PAGE_HI 4'h1
`define CA_RST 8'h00
`define CA_M_DT 7
`define CA_M_CMP 6
`define CA_M_RISE 5
`define CA_M_FALL 4
`define CA_M_MAT 3
`define CA_M_TOG 2
`define CA_M_PWM 1
`define CA_M_IRQ 0
`define CA_MODE_NOCAP_MASK 8'hdf
`define CA_A_RS1 7
`define CA_A_RS0 6
`define CA_A_FLAG 3
`define CA_A_INV 2
`define CA_A_N9H 1
`define CA_A_N9L 0
`define CA_AUX_WMASK 8'hc7
`define CA_CLK_MHZ 100
`define CA_DT_NS 40
`define CA_DT_CYC ((`CA_DT_NS * `CA_CLK_MHZ + 999) / 1000)
`endif

/* File: src/pcactl_pkg.sv */
// types and decode helpers of the counter array control block
`default_nettype none
`include "pcactl_defs.svh"
package pcactl_pkg;
  typedef struct packed {
    logic [3:0] page;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pcactl_sfr_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] last;
    logic [7:0] rld_hi;
    logic [7:0] rld_lo;
    logic upd;
    logic ovf;
  } pcactl_cnt_t;
  typedef struct packed {
    logic [3:0] cnt;
    logic prev;
    logic hi;
    logic lo;
  } pcactl_dt_t;
  typedef struct packed {
    logic ok;
    logic [2:0] idx;
  } pcactl_sel_t;

  // maps an address of a six-wide module window and the page to a module index
  function automatic pcactl_sel_t pcactl_decode(input logic [7:0] addr, input logic [7:0] base,
                                                input logic [3:0] page);
    logic [7:0] k;
    pcactl_sel_t s;
    k = addr - base;
    s = '0;
    if (k < 8'd2) begin
      s.ok = (page == `CA_PAGE_HI) || (page == `CA_PAGE_LO);
      s.idx = (page == `CA_PAGE_HI) ? 3'd6 + k[2:0] : k[2:0];
    end else if (k < 8'd6) begin
      s.ok = 1'b1;
      s.idx = k[2:0];
    end
    return s;
  endfunction

  function automatic logic [15:0] pcactl_res_mask(input logic [1:0] rs);
    logic [15:0] m;
    unique case (rs)
      2'b00: m = 16'h00ff;
      2'b01: m = 16'h03ff;
      2'b10: m = 16'h0fff;
      2'b11: m = 16'hffff;
    endcase
    return m;
  endfunction
endpackage
`default_nettype wire

/* File: src/pcactl_counter.sv */
// 16-bit base counter with high and low reload bytes
`timescale 1ns/1ps
`default_nettype none
`include "pcactl_defs.svh"
module pcactl_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire pcactl_pkg::pcactl_sfr_t sfr,
  input wire logic tick,
  output var pcactl_pkg::pcactl_cnt_t st
);
  import pcactl_pkg::*;
  pcactl_cnt_t c_reg;
  pcactl_cnt_t c_next;

  always_comb begin
    c_next = c_reg;
    c_next.upd = 1'b0;
    c_next.ovf = 1'b0;
    if (tick) begin
      c_next.upd = 1'b1;
      c_next.last = c_reg.cnt;
      if (c_reg.cnt == 16'hffff) begin
        c_next.cnt = {c_reg.rld_hi, c_reg.rld_lo};
        c_next.ovf = 1'b1;
      end else begin
        c_next.cnt = c_reg.cnt + 16'h0001;
      end
    end
    if (sfr.wr) begin
      case (sfr.addr)
        `CA_CNT_LO: c_next.cnt[7:0] = sfr.wdata;
        `CA_CNT_HI: c_next.cnt[15:8] = sfr.wdata;
        `CA_RLD_LO: c_next.rld_lo = sfr.wdata;
        `CA_RLD_HI: c_next.rld_hi = sfr.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c_reg <= '0;
    end else if (ce) begin
      c_reg <= c_next;
    end
  end

  assign st = c_reg;

  reload_on_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && tick && !sfr.wr && c_reg.cnt == 16'hffff) |=> (c_reg.cnt == {$past(c_reg.rld_hi), $past(c_reg.rld_lo)}))
    else $error("base counter did not take the reload bytes on wrap");
endmodule
`default_nettype wire

/* File: src/pcactl_deadtime.sv */
// dead-time insertion for one complementary output pair
`timescale 1ns/1ps
`default_nettype none
`include "pcactl_defs.svh"
module pcactl_deadtime (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic en,
  input wire logic src,
  input wire logic alt_hi,
  input wire logic alt_lo,
  output logic hi,
  output logic lo
);
  import pcactl_pkg::*;
  pcactl_dt_t d_reg;
  pcactl_dt_t d_next;

  always_comb begin
    d_next = d_reg;
    d_next.prev = src;
    if (!en) begin
      d_next.cnt = 4'h0;
      d_next.hi = alt_hi;
      d_next.lo = alt_lo;
    end else begin
      if (src != d_reg.prev) begin
        d_next.cnt = 4'(`CA_DT_CYC);
      end else if (d_reg.cnt != 4'h0) begin
        d_next.cnt = d_reg.cnt - 4'h1;
      end
      d_next.hi = src && (src == d_reg.prev) && (d_next.cnt == 4'h0);
      d_next.lo = !src && (src == d_reg.prev) && (d_next.cnt == 4'h0);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_reg <= '0;
    end else if (ce) begin
      d_reg <= d_next;
    end
  end

  assign hi = d_reg.hi;
  assign lo = d_reg.lo;

  dead_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && en && src != d_reg.prev) |=> (!hi && !lo) [*4])
    else $error("pair output driven inside the dead-time gap");
endmodule
`default_nettype wire

/* File: src/pcactl_top.sv */
// control, time base and compare/capture modules of the eight-channel counter array
// How it works
// - modules 6 and 7 set their aux flag bit 3 on match; only software clears it
// - high and low reload bytes are read/write registers resetting to zero
// - each of eight modules has its own mode register including interrupt enable
// - mode bit 7 inserts dead-time on modules 0, 2, 4 running PWM in buffer mode only
// - mode bit 6 enables the module comparator; cleared disables matching
// - mode bit 5 captures on rising pin edge; modules 6, 7 never capture
// - mode bit 4 captures on falling pin edge where capture exists
// - both capture enables set capture on every pin transition while mode bit 1 (PWM) is clear
// - mode bit 3 lets a compare match set the module flag
// - mode bit 2 lets a compare match invert the module pin
// - mode bit 1 makes the module pin a PWM output
// - mode bit 0 lets a set module flag request an interrupt
// - two value bytes per module: capture loads them, compare uses them
// - aux register extends PWM duty from zero to full in steps of one count of the selected resolution
// - counter overflow loads the reload bytes into the counter
// - aux resolution field picks 8, 10, 12 or 16-bit PWM wrap
// - aux bit 2 inverts the module output before the pin
// - aux bits 1 and 0 are ninth bits of high and low value bytes
`timescale 1ns/1ps
`default_nettype none
`include "pcactl_defs.svh"
module pcactl_top (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [3:0] SFR_PAGE,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic COUNT_TICK,
  output logic COUNT_OVERFLOW,
  input wire logic [2:0] PAIR_BUFFER_ENABLE,
  input wire logic [7:0] MODULE_IO_PIN_I,
  output logic [7:0] MODULE_IO_PIN_O,
  output logic [7:0] MODULE_IO_PIN_OE,
  output logic [2:0] PWM_HIGH_SIDE_OUT,
  output logic [2:0] PWM_LOW_SIDE_OUT,
  output logic [7:0] MODULE_IRQ
);
  import pcactl_pkg::*;

  typedef struct packed {
    logic [7:0][7:0] mode;
    logic [7:0][7:0] cmp_hi;
    logic [7:0][7:0] cmp_lo;
    logic [7:0][7:0] aux;
    logic [7:0] flag;
    logic [7:0] out;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
    logic [7:0] pin_o;
    logic [7:0] pin_oe;
    logic [7:0] match;
    logic [7:0] capt;
    logic [7:0] rdata;
  } pcactl_state_t;

  pcactl_state_t r_reg;
  pcactl_state_t r_next;
  pcactl_sfr_t sfr;
  pcactl_cnt_t cnt;
  pcactl_sel_t sel_mode;
  pcactl_sel_t sel_hi;
  pcactl_sel_t sel_lo;
  pcactl_sel_t sel_aux;
  logic [7:0] hit;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] wrap;
  logic [7:0] irq;
  logic [15:0] msk;
  logic [16:0] pv;
  logic [7:0] rd_val;
  logic [2:0] dt_en;

  assign sfr.page = SFR_PAGE;
  assign sfr.addr = SFR_ADDR;
  assign sfr.wr = SFR_WR;
  assign sfr.rd = SFR_RD;
  assign sfr.wdata = SFR_WDATA;

  pcactl_counter u_counter (
    .clk(MCLK),
    .rst_n(RESETN),
    .ce(CE),
    .sfr(sfr),
    .tick(COUNT_TICK),
    .st(cnt)
  );

  always_comb begin
    sel_mode = pcactl_decode(SFR_ADDR, `CA_MODE_BASE, SFR_PAGE);
    sel_hi = pcactl_decode(SFR_ADDR, `CA_CMPH_BASE, SFR_PAGE);
    sel_lo = pcactl_decode(SFR_ADDR, `CA_CMPL_BASE, SFR_PAGE);
    sel_aux = pcactl_decode(SFR_ADDR, `CA_AUX_BASE, SFR_PAGE);
  end

  always_comb begin
    r_next = r_reg;
    r_next.match = '0;
    r_next.capt = '0;
    r_next.sync1 = MODULE_IO_PIN_I;
    r_next.sync2 = r_reg.sync1;
    r_next.prev = r_reg.sync2;
    hit = '0;
    rise = '0;
    fall = '0;
    wrap = '0;
    irq = '0;
    msk = 16'h0000;
    pv = 17'h00000;
    rd_val = `CA_RST;
    // software writes first, so hardware events below win over a clear
    if (SFR_WR) begin
      if (sel_mode.ok) begin
        if (sel_mode.idx >= 3'd6) begin
          r_next.mode[sel_mode.idx] = SFR_WDATA & `CA_MODE_NOCAP_MASK;
        end else begin
          r_next.mode[sel_mode.idx] = SFR_WDATA;
        end
      end
      if (sel_hi.ok) begin
        r_next.cmp_hi[sel_hi.idx] = SFR_WDATA;
      end
      if (sel_lo.ok) begin
        r_next.cmp_lo[sel_lo.idx] = SFR_WDATA;
      end
      if (sel_aux.ok) begin
        r_next.aux[sel_aux.idx] = SFR_WDATA & `CA_AUX_WMASK;
        if (sel_aux.idx >= 3'd6) begin
          r_next.flag[sel_aux.idx] = SFR_WDATA[`CA_A_FLAG];
        end
      end
      if (SFR_ADDR == `CA_CTRL) begin
        r_next.flag[5:0] = SFR_WDATA[5:0];
      end
    end
    for (int i = 0; i < 8; i++) begin
      hit[i] = r_reg.mode[i][`CA_M_CMP] && cnt.upd && (cnt.cnt == {r_reg.cmp_hi[i], r_reg.cmp_lo[i]});
      if (i < 6) begin
        rise[i] = r_reg.mode[i][`CA_M_RISE] && r_reg.sync2[i] && !r_reg.prev[i];
        fall[i] = r_reg.mode[i][`CA_M_FALL] && !r_reg.sync2[i] && r_reg.prev[i];
      end
      msk = pcactl_res_mask(r_reg.aux[i][`CA_A_RS1:`CA_A_RS0]);
      wrap[i] = cnt.upd && ((cnt.last & msk) == msk);
      if (r_reg.aux[i][`CA_A_RS1:`CA_A_RS0] == 2'b00) begin
        pv = {8'h00, r_reg.aux[i][`CA_A_N9L], r_reg.cmp_lo[i]};
      end else begin
        pv = ({1'b0, r_reg.cmp_hi[i], r_reg.cmp_lo[i]} & {1'b0, msk})
           | (r_reg.aux[i][`CA_A_N9H] ? {1'b0, msk} + 17'h00001 : 17'h00000);
      end
      if (r_reg.mode[i][`CA_M_PWM]) begin
        r_next.out[i] = {1'b0, cnt.cnt & msk} >= pv;
        if (wrap[i] && r_reg.aux[i][`CA_A_RS1:`CA_A_RS0] == 2'b00) begin
          r_next.cmp_lo[i] = r_reg.cmp_hi[i];
          r_next.aux[i][`CA_A_N9L] = r_reg.aux[i][`CA_A_N9H];
        end
      end else if (hit[i] && r_reg.mode[i][`CA_M_TOG]) begin
        r_next.out[i] = !r_reg.out[i];
      end
      if ((rise[i] || fall[i]) && !r_reg.mode[i][`CA_M_PWM]) begin
        r_next.cmp_hi[i] = cnt.cnt[15:8];
        r_next.cmp_lo[i] = cnt.cnt[7:0];
        r_next.capt[i] = 1'b1;
      end
      r_next.match[i] = hit[i];
      if ((hit[i] && r_reg.mode[i][`CA_M_MAT]) || r_next.capt[i]) begin
        r_next.flag[i] = 1'b1;
      end
      r_next.pin_o[i] = r_next.out[i] ^ r_next.aux[i][`CA_A_INV];
      r_next.pin_oe[i] = r_next.mode[i][`CA_M_PWM] || r_next.mode[i][`CA_M_TOG];
      irq[i] = r_reg.flag[i] && r_reg.mode[i][`CA_M_IRQ];
    end
    if (SFR_RD) begin
      if (SFR_ADDR == `CA_CTRL) begin
        rd_val = {2'b00, r_reg.flag[5:0]};
      end else if (SFR_ADDR == `CA_CNT_LO) begin
        rd_val = cnt.cnt[7:0];
      end else if (SFR_ADDR == `CA_CNT_HI) begin
        rd_val = cnt.cnt[15:8];
      end else if (SFR_ADDR == `CA_RLD_LO) begin
        rd_val = cnt.rld_lo;
      end else if (SFR_ADDR == `CA_RLD_HI) begin
        rd_val = cnt.rld_hi;
      end else if (sel_mode.ok) begin
        rd_val = r_reg.mode[sel_mode.idx];
      end else if (sel_hi.ok) begin
        rd_val = r_reg.cmp_hi[sel_hi.idx];
      end else if (sel_lo.ok) begin
        rd_val = r_reg.cmp_lo[sel_lo.idx];
      end else if (sel_aux.ok) begin
        rd_val = r_reg.aux[sel_aux.idx];
        if (sel_aux.idx >= 3'd6) begin
          rd_val[`CA_A_FLAG] = r_reg.flag[sel_aux.idx];
        end
      end
      r_next.rdata = rd_val;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      r_reg <= '0;
    end else if (CE) begin
      r_reg <= r_next;
    end
  end

  // dead-time only on even modules of a pair running PWM in buffer mode
  for (genvar p = 0; p < 3; p++) begin : g_pair
    assign dt_en[p] = r_reg.mode[2*p][`CA_M_DT] && r_reg.mode[2*p][`CA_M_PWM] && PAIR_BUFFER_ENABLE[p];
    pcactl_deadtime u_dt (
      .clk(MCLK),
      .rst_n(RESETN),
      .ce(CE),
      .en(dt_en[p]),
      .src(r_reg.pin_o[2*p]),
      .alt_hi(r_reg.pin_o[2*p]),
      .alt_lo(r_reg.pin_o[2*p+1]),
      .hi(PWM_HIGH_SIDE_OUT[p]),
      .lo(PWM_LOW_SIDE_OUT[p])
    );
  end

  assign SFR_RDATA = r_reg.rdata;
  assign COUNT_OVERFLOW = cnt.ovf;
  assign MODULE_IO_PIN_O = r_reg.pin_o;
  assign MODULE_IO_PIN_OE = r_reg.pin_oe;
  assign MODULE_IRQ = irq;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);

  for (genvar g = 0; g < 8; g++) begin : g_chk
    flag_on_match_a: assert property ((CE && hit[g] && r_reg.mode[g][`CA_M_MAT]) |=> r_reg.flag[g])
      else $error("match did not set the module flag");
    flag_sticky_a: assert property ((CE && r_reg.flag[g] && !SFR_WR) |=> r_reg.flag[g])
      else $error("module flag cleared without a software write");
    toggle_on_match_a: assert property ((CE && hit[g] && r_reg.mode[g][`CA_M_TOG] && !r_reg.mode[g][`CA_M_PWM])
      |=> (r_reg.out[g] != $past(r_reg.out[g])))
      else $error("match did not invert the module output");
    comparator_off_a: assert property ((CE && !r_reg.mode[g][`CA_M_CMP]) |=> !r_reg.match[g])
      else $error("match seen with comparator disabled");
    irq_request_a: assert property ((CE && hit[g] && r_reg.mode[g][`CA_M_MAT] && r_reg.mode[g][`CA_M_IRQ])
      |=> MODULE_IRQ[g])
      else $error("flag with interrupt enable raised no request");
    pwm_reload_a: assert property ((CE && r_reg.mode[g][`CA_M_PWM] && wrap[g]
      && r_reg.aux[g][`CA_A_RS1:`CA_A_RS0] == 2'b00 && !SFR_WR) |=> (r_reg.cmp_lo[g] == $past(r_reg.cmp_hi[g])))
      else $error("8-bit PWM wrap did not reload the duty byte");
    pin_invert_a: assert property ((CE && r_reg.pin_oe[g]) |-> (MODULE_IO_PIN_O[g] == (r_reg.out[g] ^ r_reg.aux[g][`CA_A_INV])))
      else $error("pin level does not follow output and invert bit");
    pin_enable_a: assert property (MODULE_IO_PIN_OE[g] ==
      (r_reg.mode[g][`CA_M_PWM] || r_reg.mode[g][`CA_M_TOG]))
      else $error("pin drive enable does not follow the mode bits");
    irq_masked_a: assert property ((CE && !r_reg.mode[g][`CA_M_IRQ]) |-> !MODULE_IRQ[g])
      else $error("interrupt request without its enable");
    pwm_level_a: assert property ((CE && r_reg.mode[g][`CA_M_PWM]
      && r_reg.aux[g][`CA_A_RS1:`CA_A_RS0] == 2'b00) |=> r_reg.out[g]
      == ({1'b0, $past(cnt.cnt[7:0])} >= {$past(r_reg.aux[g][`CA_A_N9L]), $past(r_reg.cmp_lo[g])}))
      else $error("pwm level does not follow count and duty");
    zero_duty_a: assert property ((CE && r_reg.mode[g][`CA_M_PWM] && r_reg.aux[g][`CA_A_N9L]
      && r_reg.aux[g][`CA_A_RS1:`CA_A_RS0] == 2'b00) |=> !r_reg.out[g])
      else $error("ninth duty bit did not hold the output low");
    pwm_no_capture_a: assert property ((CE && r_reg.mode[g][`CA_M_PWM]) |=> !r_reg.capt[g])
      else $error("capture taken while the module runs pwm");
    out_hold_a: assert property ((CE && !r_reg.mode[g][`CA_M_PWM] && !(hit[g] && r_reg.mode[g][`CA_M_TOG]))
      |=> r_reg.out[g] == $past(r_reg.out[g]))
      else $error("module output changed without a match or pwm");
    flag_quiet_a: assert property ((CE && !r_reg.flag[g] && !SFR_WR && !hit[g] && !rise[g] && !fall[g])
      |=> !r_reg.flag[g])
      else $error("module flag set without an event");
    if (g < 6) begin : g_cap
      capture_value_a: assert property ((CE && (rise[g] || fall[g]) && !r_reg.mode[g][`CA_M_PWM])
        |=> ({r_reg.cmp_hi[g], r_reg.cmp_lo[g]} == $past(cnt.cnt)) && r_reg.flag[g])
        else $error("capture did not load the counter value");
    end else begin : g_nocap
      no_capture_a: assert property ((CE && SFR_WR && sel_mode.ok && sel_mode.idx == 3'(g))
        |=> !r_reg.mode[g][`CA_M_RISE] ##1 !r_reg.capt[g])
        else $error("capture-less module accepted a capture enable");
    end
  end

  count_readback_a: assert property ((CE && SFR_RD && SFR_ADDR == `CA_CNT_LO) |=> (SFR_RDATA == $past(cnt.cnt[7:0])))
    else $error("low counter byte read back wrong");
  reload_readback_a: assert property ((CE && SFR_RD && SFR_ADDR == `CA_RLD_HI) |=> (SFR_RDATA == $past(cnt.rld_hi)))
    else $error("high reload byte read back wrong");
  // register bus and time base
  overflow_pulse_a: assert property ((CE && COUNT_TICK && cnt.cnt == 16'hffff) |=> COUNT_OVERFLOW)
    else $error("counter wrap gave no overflow pulse");
  no_overflow_a: assert property ((CE && !COUNT_TICK) |=> !COUNT_OVERFLOW)
    else $error("overflow pulse without a count tick");
  count_step_a: assert property ((CE && COUNT_TICK && !SFR_WR && cnt.cnt != 16'hffff)
    |=> cnt.cnt == $past(cnt.cnt) + 16'h0001)
    else $error("base counter did not advance by one");
  count_hold_a: assert property ((CE && !COUNT_TICK && !SFR_WR) |=> $stable(cnt.cnt))
    else $error("base counter moved without a tick or write");
  count_high_write_a: assert property ((CE && SFR_WR && SFR_ADDR == `CA_CNT_HI)
    |=> cnt.cnt[15:8] == $past(SFR_WDATA))
    else $error("high counter byte write lost");
  count_low_write_a: assert property ((CE && SFR_WR && SFR_ADDR == `CA_CNT_LO)
    |=> cnt.cnt[7:0] == $past(SFR_WDATA))
    else $error("low counter byte write lost");
  reload_low_write_a: assert property ((CE && SFR_WR && SFR_ADDR == `CA_RLD_LO)
    |=> cnt.rld_lo == $past(SFR_WDATA))
    else $error("low reload byte write lost");
  reload_high_write_a: assert property ((CE && SFR_WR && SFR_ADDR == `CA_RLD_HI)
    |=> cnt.rld_hi == $past(SFR_WDATA))
    else $error("high reload byte write lost");
  mode_write_a: assert property ((CE && SFR_WR && sel_mode.ok && sel_mode.idx < 3'd6)
    |=> r_reg.mode[$past(sel_mode.idx)] == $past(SFR_WDATA))
    else $error("mode register write lost");
  mode_readback_a: assert property ((CE && SFR_RD && sel_mode.ok)
    |=> SFR_RDATA == $past(r_reg.mode[sel_mode.idx]))
    else $error("mode register read back wrong");
  ctrl_readback_a: assert property ((CE && SFR_RD && SFR_ADDR == `CA_CTRL)
    |=> SFR_RDATA == {2'b00, $past(r_reg.flag[5:0])})
    else $error("module flags read back wrong");
  aux_flag_read_a: assert property ((CE && SFR_RD && sel_aux.ok && sel_aux.idx >= 3'd6)
    |=> SFR_RDATA[`CA_A_FLAG] == $past(r_reg.flag[sel_aux.idx]))
    else $error("aux flag bit read back wrong");
  value_readback_a: assert property ((CE && SFR_RD && sel_hi.ok)
    |=> SFR_RDATA == $past(r_reg.cmp_hi[sel_hi.idx]))
    else $error("high value byte read back wrong");
  low_value_readback_a: assert property ((CE && SFR_RD && sel_lo.ok)
    |=> SFR_RDATA == $past(r_reg.cmp_lo[sel_lo.idx]))
    else $error("low value byte read back wrong");
  read_hold_a: assert property ((CE && !SFR_RD) |=> $stable(SFR_RDATA))
    else $error("read data changed without a read");

  capture_seen_c: cover property (CE && r_reg.capt[1] ##1 MODULE_IRQ[1]);
  pwm_reload_c: cover property (CE && r_reg.mode[4][`CA_M_PWM] && wrap[4]);
  toggle_seen_c: cover property (CE && hit[1] && r_reg.mode[1][`CA_M_TOG]);
  pwm_wrap_c: cover property (CE && r_reg.mode[6][`CA_M_PWM] && wrap[6]);
  deadtime_c: cover property (dt_en[0] ##1 PWM_HIGH_SIDE_OUT[0] ##[1:40] PWM_LOW_SIDE_OUT[0]);
endmodule
`default_nettype wire

/* File: testbench/pcactl_pin_model.sv */
// pin-side partner: external sources on the module pins, overridden where the block drives
`timescale 1ns/1ps
`default_nettype none
module pcactl_pin_model (
  input wire logic [7:0] ext_level,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_i
);
  // wire level seen by the block: its own drive wins, else the outside source
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_i[i] = pin_oe[i] ? pin_o[i] : ext_level[i];
    end
  end
endmodule
`default_nettype wire

/* File: testbench/pcactl_bench.sv */
// self-checking bench of the counter array control block
`timescale 1ns/1ps
`default_nettype none
module pcactl_bench;
  logic MCLK = 1'b0;
  logic RESETN = 1'b0;
  logic CE = 1'b1;
  logic [7:0] SFR_ADDR = 8'h00;
  logic [3:0] SFR_PAGE = 4'h0;
  logic SFR_WR = 1'b0;
  logic SFR_RD = 1'b0;
  logic [7:0] SFR_WDATA = 8'h00;
  logic [7:0] SFR_RDATA;
  logic COUNT_TICK = 1'b0;
  logic COUNT_OVERFLOW;
  logic [2:0] PAIR_BUFFER_ENABLE = 3'h0;
  logic [7:0] MODULE_IO_PIN_I;
  logic [7:0] MODULE_IO_PIN_O;
  logic [7:0] MODULE_IO_PIN_OE;
  logic [2:0] PWM_HIGH_SIDE_OUT;
  logic [2:0] PWM_LOW_SIDE_OUT;
  logic [7:0] MODULE_IRQ;
  logic [7:0] ext_level = 8'h00;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  pcactl_top dut (.MCLK(MCLK), .RESETN(RESETN), .CE(CE), .SFR_ADDR(SFR_ADDR), .SFR_PAGE(SFR_PAGE),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
    .COUNT_TICK(COUNT_TICK), .COUNT_OVERFLOW(COUNT_OVERFLOW), .PAIR_BUFFER_ENABLE(PAIR_BUFFER_ENABLE),
    .MODULE_IO_PIN_I(MODULE_IO_PIN_I), .MODULE_IO_PIN_O(MODULE_IO_PIN_O), .MODULE_IO_PIN_OE(MODULE_IO_PIN_OE),
    .PWM_HIGH_SIDE_OUT(PWM_HIGH_SIDE_OUT), .PWM_LOW_SIDE_OUT(PWM_LOW_SIDE_OUT), .MODULE_IRQ(MODULE_IRQ));
  pcactl_pin_model pins (.ext_level(ext_level), .pin_o(MODULE_IO_PIN_O), .pin_oe(MODULE_IO_PIN_OE),
    .pin_i(MODULE_IO_PIN_I));

  always #5 MCLK = ~MCLK;

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input int pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    SFR_PAGE <= 4'(pg);
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    SFR_WR <= 1'b1;
    @(posedge MCLK);
    SFR_WR <= 1'b0;
  endtask
  task automatic rc(input int pg, input logic [7:0] a, input logic [7:0] exp);
    @(posedge MCLK);
    SFR_PAGE <= 4'(pg);
    SFR_ADDR <= a;
    SFR_RD <= 1'b1;
    @(posedge MCLK);
    SFR_RD <= 1'b0;
    #1;
    chk(SFR_RDATA, exp);
  endtask
  task automatic tick();
    @(posedge MCLK);
    COUNT_TICK <= 1'b1;
    @(posedge MCLK);
    COUNT_TICK <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask
  task automatic setcnt(input logic [7:0] hi, input logic [7:0] lo);
    wr(0, 8'he9, lo);
    wr(0, 8'hf9, hi);
  endtask

  task automatic t_regs();
    rc(0, 8'hce, 8'h00);
    rc(0, 8'hcf, 8'h00);
    rc(0, 8'he9, 8'h00);
    rc(0, 8'hf9, 8'h00);
    wr(5, 8'hce, 8'h5a);
    wr(5, 8'hcf, 8'ha5);
    wr(0, 8'he9, 8'h3c);
    rc(0, 8'hce, 8'h5a);
    rc(0, 8'hcf, 8'ha5);
    rc(3, 8'he9, 8'h3c);
    rc(0, 8'hf9, 8'h00);
    rc(0, 8'h80, 8'h00);
    for (int k = 0; k < 8; k++) rc(k > 5 ? 1 : 0, 8'hda + 8'(k % 6), 8'h00);
    for (int k = 0; k < 8; k++) wr(k > 5 ? 1 : 0, 8'hda + 8'(k % 6), 8'(k * 2));
    for (int k = 0; k < 8; k++) rc(k > 5 ? 1 : 0, 8'hda + 8'(k % 6), 8'(k * 2));
    for (int k = 0; k < 8; k++) wr(k > 5 ? 1 : 0, 8'hda + 8'(k % 6), 8'h00);
    wr(1, 8'hda, 8'h30);
    rc(1, 8'hda, 8'h10);
    wr(1, 8'hda, 8'h00);
    wr(0, 8'hd8, 8'h00);
    $display("register test done");
  endtask

  task automatic t_reload();
    logic seen;
    wr(0, 8'hce, 8'h34);
    wr(0, 8'hcf, 8'h12);
    setcnt(8'hff, 8'hff);
    tick();
    #1 seen = COUNT_OVERFLOW;
    @(posedge MCLK);
    #1 seen = seen | COUNT_OVERFLOW;
    chk({7'h00, seen}, 8'h01);
    rc(0, 8'he9, 8'h34);
    rc(0, 8'hf9, 8'h12);
    $display("reload test done");
  endtask

  task automatic t_match();
    logic lvl;
    for (int m = 2; m < 4; m++) begin
      wr(0, 8'hea + 8'(m), 8'h05);
      wr(0, 8'hfa + 8'(m), 8'h01);
    end
    wr(0, 8'hdc, 8'h09);
    setcnt(8'h01, 8'h04);
    tick();
    idle(3);
    rc(0, 8'hd8, 8'h00);
    wr(0, 8'hdc, 8'h49);
    wr(0, 8'hdd, 8'h44);
    setcnt(8'h01, 8'h04);
    #1 lvl = MODULE_IO_PIN_O[3];
    tick();
    idle(3);
    rc(0, 8'hd8, 8'h04);
    chk(MODULE_IRQ, 8'h04);
    chk({7'h00, MODULE_IO_PIN_O[3]}, {7'h00, ~lvl});
    rc(0, 8'hec, 8'h05);
    wr(0, 8'hdc, 8'h48);
    idle(1);
    chk(MODULE_IRQ, 8'h00);
    wr(0, 8'hdc, 8'h00);
    wr(0, 8'hdd, 8'h00);
    wr(0, 8'hd8, 8'h00);
    $display("match test done");
  endtask

  task automatic t_flag67();
    wr(1, 8'hda, 8'h48);
    wr(1, 8'hea, 8'h05);
    wr(1, 8'hfa, 8'h01);
    setcnt(8'h01, 8'h04);
    tick();
    idle(3);
    rc(0, 8'hf2, 8'h00);
    rc(1, 8'hf2, 8'h08);
    idle(20);
    rc(1, 8'hf2, 8'h08);
    wr(1, 8'hf2, 8'h00);
    rc(1, 8'hf2, 8'h00);
    wr(1, 8'hda, 8'h00);
    $display("aux flag test done");
  endtask

  task automatic t_capture();
    wr(0, 8'hdb, 8'h31);
    setcnt(8'h0a, 8'hbc);
    ext_level[1] <= 1'b1;
    idle(6);
    rc(0, 8'heb, 8'hbc);
    rc(0, 8'hfb, 8'h0a);
    rc(0, 8'hd8, 8'h02);
    chk(MODULE_IRQ, 8'h02);
    wr(0, 8'hd8, 8'h00);
    setcnt(8'h0d, 8'hef);
    ext_level[1] <= 1'b0;
    idle(6);
    rc(0, 8'heb, 8'hef);
    rc(0, 8'hfb, 8'h0d);
    wr(0, 8'hdb, 8'h10);
    setcnt(8'h01, 8'h11);
    ext_level[1] <= 1'b1;
    idle(6);
    rc(0, 8'heb, 8'hef);
    ext_level[1] <= 1'b0;
    idle(6);
    rc(0, 8'heb, 8'h11);
    wr(0, 8'hdb, 8'h00);
    $display("capture test done");
  endtask

  task automatic t_pwm();
    wr(0, 8'hee, 8'h80);
    wr(0, 8'hfe, 8'h12);
    setcnt(8'h04, 8'h80);
    wr(0, 8'hde, 8'h42);
    for (int r = 0; r < 4; r++) begin
      wr(0, 8'hf6, 8'(r << 6));
      idle(3);
      chk({7'h00, MODULE_IO_PIN_O[4]}, 8'(~r & 1));
    end
    chk({7'h00, MODULE_IO_PIN_OE[4]}, 8'h01);
    wr(0, 8'hf6, 8'h04);
    idle(3);
    chk({7'h00, MODULE_IO_PIN_O[4]}, 8'h00);
    wr(0, 8'hf6, 8'h01);
    idle(3);
    chk({7'h00, MODULE_IO_PIN_O[4]}, 8'h00);
    wr(0, 8'hee, 8'h00);
    wr(0, 8'hf6, 8'h00);
    idle(3);
    chk({7'h00, MODULE_IO_PIN_O[4]}, 8'h01);
    setcnt(8'h04, 8'hff);
    tick();
    idle(3);
    rc(0, 8'hee, 8'h12);
    chk({7'h00, MODULE_IO_PIN_O[4]}, 8'h00);
    wr(0, 8'hde, 8'h00);
    idle(3);
    chk({7'h00, MODULE_IO_PIN_OE[4]}, 8'h00);
    $display("pwm test done");
  endtask

  task automatic t_dead();
    @(posedge MCLK);
    PAIR_BUFFER_ENABLE <= 3'b001;
    wr(0, 8'hea, 8'h80);
    setcnt(8'h00, 8'h80);
    wr(0, 8'hda, 8'hc2);
    idle(12);
    chk({6'h00, PWM_HIGH_SIDE_OUT[0], PWM_LOW_SIDE_OUT[0]}, 8'h02);
    wr(0, 8'he9, 8'h00);
    idle(4);
    chk({6'h00, PWM_HIGH_SIDE_OUT[0], PWM_LOW_SIDE_OUT[0]}, 8'h00);
    idle(10);
    chk({6'h00, PWM_HIGH_SIDE_OUT[0], PWM_LOW_SIDE_OUT[0]}, 8'h01);
    $display("dead-time test done");
  endtask

  initial begin
    repeat (16) @(posedge MCLK);
    RESETN <= 1'b1;
    t_regs();
    t_reload();
    t_match();
    t_flag67();
    t_capture();
    t_pwm();
    t_dead();
    wrap_up();
  end
endmodule
`default_nettype wire
